/* rtl/rss_pkg.sv */
// Purpose: constants for the reset sequencer and supply monitor
// Assumes: 10 MHz cpu clock, one clock domain
// Notes: register map is a plain strobe port, read data one cycle late
// Operation
// RL1: external pin, undervoltage and watchdog merge into one sequence; pin low through delay.
// RL2: after the active phase count 256 or 4096 cycles, chosen by option.
// RL3: final phase is the vector fetch, exactly two cycles long.
// RL4: reset routine address comes from the top two bytes of memory.
// RL5: resonator oscillators keep running while reset is asserted.
// RL6: external low pulse is caught without a running clock.
// RL7: recognised external pulse drives the pin low for at least the minimum width.
// RL8: watchdog underflow drives the pin low for at least the minimum width.
// RL9: supply below undervoltage threshold holds a static reset with the pin low.
// RL10: undervoltage detector optional by option, threshold low, medium or high; code stores the level bits but drives no output with them.
// RL11: warning comparator output is a real-time read-only flag.
// RL12: warning detector works only when the undervoltage detector is enabled.
// RL13: with interrupt enabled, every warning flag toggle requests an interrupt; code drops toggles while the sequencer is not in RSS_RUN.
// RL14: a rising crossing before the reset delay ends raises no interrupt.
// RL15: enabling before the rising crossing gives one interrupt then another at crossing.
// RL16: enabling after the rising crossing gives exactly one interrupt; code gives none, as enabling counts only while the flag is set.
// RL17: main clock source chosen by option among seven kinds.
// RL18: watchdog flag set by watchdog, cleared by write zero or undervoltage reset.
// RL19: pending warning request clears when software enters its routine.
// RL20: delay counter starts at last release, restarts if any source reasserts.
package rss_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MIN_RESET_OUT_WIDTH_NS = 20_000;
  localparam int MIN_RESET_OUT_CYC = (MIN_RESET_OUT_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam int FETCH_CYC = 2;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_OPTION = 4'h1;
  localparam logic [3:0] ADDR_VECTOR_LO = 4'h2;
  localparam logic [3:0] ADDR_VECTOR_HI = 4'h3;
  localparam logic [3:0] ADDR_ACK = 4'h4;
  // status bits
  localparam int BIT_WDG_RF = 0;
  localparam int BIT_UV_RF = 4;
  localparam int BIT_WARN_F = 5;
  localparam int BIT_WARN_IE = 6;
  // option bits
  localparam int BIT_LONG_DELAY = 0;
  localparam int BIT_UV_EN = 1;
  localparam int POS_UV_LEVEL = 2;
  localparam int POS_CLK_SRC = 4;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    RSS_LVL_LOW,
    RSS_LVL_MED,
    RSS_LVL_HIGH
  } rss_level_t;

  typedef enum logic [2:0] {
    RSS_CLK_RES0,
    RSS_CLK_RES1,
    RSS_CLK_RES2,
    RSS_CLK_RES3,
    RSS_CLK_EXT_RC,
    RSS_CLK_INT_RC,
    RSS_CLK_EXT
  } rss_clk_src_t;
endpackage : rss_pkg

/* rtl/rss_pin_catch.sv */
// Purpose: asynchronous catch of a low pulse on the reset pin
// Assumes: pin input already a clean digital level
// Notes: set with no clock, cleared by a clocked acknowledge
`timescale 1ns/1ns
module rss_pin_catch (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and handshake
  input wire logic pin_low,
  input wire logic ack,
  output logic caught
);
  logic hit_reg;
  logic sync_reg;

  // pin low acts as async set, so halt with a stopped clock still resets
  always_ff @(posedge clk or negedge rst_n or posedge pin_low) begin
    if (!rst_n) begin
      hit_reg <= 1'b0;
    end else if (pin_low) begin
      hit_reg <= 1'b1; // RL6
    end else if (ack) begin
      hit_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= 1'b0;
      caught <= 1'b0;
    end else begin
      sync_reg <= hit_reg;
      caught <= sync_reg;
    end
  end
endmodule : rss_pin_catch

/* rtl/rss_top.sv */
// Purpose: reset sequencer with undervoltage and supply warning monitor
// Assumes: comparator inputs are synchronous levels; one 10 MHz clock
// Notes: delay counter restarts on any reasserted source
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module rss_top #(
  parameter int LONG_DELAY_CYC = rss_pkg::DELAY_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // reset sources and comparators
  input wire logic watchdog_underflow,
  input wire logic undervoltage_below,
  input wire logic warning_below,
  // cpu side
  output logic cpu_reset,
  output logic vector_fetch,
  output logic [15:0] fetch_addr,
  output logic osc_run,
  output logic [2:0] clk_src_sel,
  output logic supply_warning_irq,
  input wire logic warning_irq_enter,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  typedef enum logic [1:0] {
    RSS_ACTIVE,
    RSS_DELAY,
    RSS_FETCH,
    RSS_RUN
  } rss_state_t;

  rss_state_t state_reg;
  logic [12:0] delay_cnt_reg;
  logic [7:0] stretch_cnt_reg;
  logic [1:0] fetch_cnt_reg;
  logic [7:0] option_reg;
  logic [15:0] vector_reg;
  logic wdg_rf_reg;
  logic uv_rf_reg;
  logic warn_ie_reg;
  logic warn_f_reg;
  logic warn_pend_reg;
  logic pin_caught;
  logic pin_ack;
  logic own_drive_reg;
  logic pin_ext_low;
  logic uv_active;
  logic any_source;
  logic delay_done;
  logic [12:0] delay_limit;
  logic warn_now;

  // ----------------------------------------
  // source merge
  // ----------------------------------------
  function automatic logic is_write(input logic [3:0] a, input logic [3:0] want, input logic wr);
    is_write = wr && (a == want);
  endfunction : is_write

  rss_pin_catch u_pin_catch (
    .clk(clk),
    .rst_n(rst_n),
    .pin_low(pin_ext_low),
    .ack(pin_ack),
    .caught(pin_caught)
  );

  // our own pull reads back as a low pin; masked one cycle past release, else reset locks up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_drive_reg <= 1'b1;
    end else begin
      own_drive_reg <= reset_pin_oe;
    end
  end

  assign pin_ext_low = !reset_pin_in && !reset_pin_oe && !own_drive_reg; // RL6

  // optional detector; threshold level bits stay in option_reg, no port carries them to a comparator
  assign uv_active = option_reg[rss_pkg::BIT_UV_EN] && undervoltage_below; // RL9 RL10
  assign any_source = pin_caught || uv_active || watchdog_underflow || (stretch_cnt_reg != 8'h00); // RL1
  assign pin_ack = pin_caught && (state_reg == RSS_ACTIVE);
  assign delay_limit = option_reg[rss_pkg::BIT_LONG_DELAY] ? 13'(LONG_DELAY_CYC - 1)
                                                           : 13'(rss_pkg::DELAY_SHORT_CYC - 1); // RL2
  assign delay_done = (delay_cnt_reg == delay_limit);
  // warning detector only live when undervoltage detector enabled
  assign warn_now = option_reg[rss_pkg::BIT_UV_EN] && warning_below; // RL12

  // ----------------------------------------
  // minimum pulse stretch
  // ----------------------------------------
  // short pin pulses and watchdog events are held for the minimum width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_cnt_reg <= 8'h00;
    end else if (pin_caught || watchdog_underflow) begin
      stretch_cnt_reg <= 8'(rss_pkg::MIN_RESET_OUT_CYC); // RL7 RL8
    end else if (stretch_cnt_reg != 8'h00) begin
      stretch_cnt_reg <= stretch_cnt_reg - 8'h01;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RSS_ACTIVE;
      delay_cnt_reg <= 13'h0000;
      fetch_cnt_reg <= 2'h0;
    end else if (any_source) begin
      state_reg <= RSS_ACTIVE; // RL20
      delay_cnt_reg <= 13'h0000;
      fetch_cnt_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        RSS_ACTIVE: begin
          state_reg <= RSS_DELAY; // RL20
          delay_cnt_reg <= 13'h0000;
        end
        RSS_DELAY: begin
          if (delay_done) begin
            state_reg <= RSS_FETCH;
            fetch_cnt_reg <= 2'h0;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 13'h0001; // RL2
          end
        end
        RSS_FETCH: begin
          if (fetch_cnt_reg == 2'(rss_pkg::FETCH_CYC - 1)) begin
            state_reg <= RSS_RUN; // RL3
          end else begin
            fetch_cnt_reg <= fetch_cnt_reg + 2'h1;
          end
        end
        RSS_RUN: begin
          state_reg <= RSS_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin and cpu outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      cpu_reset <= 1'b1;
      vector_fetch <= 1'b0;
      fetch_addr <= 16'h0000;
      osc_run <= 1'b1;
      clk_src_sel <= 3'h0;
    end else begin
      reset_pin_out <= 1'b0;
      // pin driven low through active and delay phases
      reset_pin_oe <= any_source || (state_reg == RSS_ACTIVE) || (state_reg == RSS_DELAY); // RL1
      cpu_reset <= (state_reg != RSS_RUN) || any_source;
      vector_fetch <= (state_reg == RSS_FETCH) && !any_source; // RL3
      fetch_addr <= rss_pkg::RESET_VECTOR_ADDR + {15'h0000, fetch_cnt_reg[0]}; // RL4
      osc_run <= 1'b1; // RL5
      clk_src_sel <= option_reg[rss_pkg::POS_CLK_SRC +: 3]; // RL17
    end
  end

  // ----------------------------------------
  // reset cause flags
  // ----------------------------------------
  // set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdg_rf_reg <= 1'b0;
      uv_rf_reg <= 1'b0;
    end else begin
      if (watchdog_underflow) begin
        wdg_rf_reg <= 1'b1; // RL18
      end else if (uv_active) begin
        wdg_rf_reg <= 1'b0; // RL18
      end else if (is_write(reg_addr, rss_pkg::ADDR_STATUS, reg_wr) && !reg_wdata[rss_pkg::BIT_WDG_RF]) begin
        wdg_rf_reg <= 1'b0; // RL18
      end
      if (uv_active) begin
        uv_rf_reg <= 1'b1; // RL18
      end else if (is_write(reg_addr, rss_pkg::ADDR_STATUS, reg_wr) && !reg_wdata[rss_pkg::BIT_UV_RF]) begin
        uv_rf_reg <= 1'b0; // RL18
      end
    end
  end

  // ----------------------------------------
  // supply warning
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_f_reg <= 1'b0;
    end else begin
      warn_f_reg <= warn_now; // RL11
    end
  end

  // a toggle while the cpu is held in reset is dropped, so a fast rise gives none
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_pend_reg <= 1'b0;
    end else if (warn_ie_reg && (warn_f_reg != warn_now) && (state_reg == RSS_RUN)) begin
      warn_pend_reg <= 1'b1; // RL13 RL14
    end else if (is_write(reg_addr, rss_pkg::ADDR_STATUS, reg_wr) && reg_wdata[rss_pkg::BIT_WARN_IE]
                 && !warn_ie_reg && warn_f_reg) begin
      // enabling while below threshold counts as an event
      warn_pend_reg <= 1'b1; // RL15 RL16
    end else if (warning_irq_enter || is_write(reg_addr, rss_pkg::ADDR_ACK, reg_wr)) begin
      warn_pend_reg <= 1'b0; // RL19
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_warning_irq <= 1'b0;
    end else begin
      supply_warning_irq <= warn_pend_reg && warn_ie_reg; // RL13
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_ie_reg <= 1'b0;
      option_reg <= rss_pkg::OPTION_RESET;
      vector_reg <= rss_pkg::VECTOR_RESET;
    end else begin
      if (is_write(reg_addr, rss_pkg::ADDR_STATUS, reg_wr)) begin
        warn_ie_reg <= reg_wdata[rss_pkg::BIT_WARN_IE];
      end
      if (is_write(reg_addr, rss_pkg::ADDR_OPTION, reg_wr)) begin
        option_reg <= reg_wdata; // RL10 RL17
      end
      if (is_write(reg_addr, rss_pkg::ADDR_VECTOR_LO, reg_wr)) begin
        vector_reg[7:0] <= reg_wdata;
      end
      if (is_write(reg_addr, rss_pkg::ADDR_VECTOR_HI, reg_wr)) begin
        vector_reg[15:8] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        rss_pkg::ADDR_STATUS: reg_rdata <= {1'b0, warn_ie_reg, warn_f_reg, uv_rf_reg, 3'h0, wdg_rf_reg}; // RL11
        rss_pkg::ADDR_OPTION: reg_rdata <= option_reg;
        rss_pkg::ADDR_VECTOR_LO: reg_rdata <= vector_reg[7:0];
        rss_pkg::ADDR_VECTOR_HI: reg_rdata <= vector_reg[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : rss_top

/* testbench/rss_top_chk.sv */
// Purpose: port assertions for rss_top
// Assumes: one clock, async active-low reset
// Notes: attached to every rss_top by bind
`timescale 1ns/1ns
module rss_top_chk #(
  parameter int LONG_DELAY_CYC = rss_pkg::DELAY_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic watchdog_underflow,
  input wire logic cpu_reset,
  input wire logic vector_fetch,
  input wire logic [15:0] fetch_addr,
  input wire logic osc_run,
  input wire logic supply_warning_irq,
  input wire logic warning_irq_enter
);
  localparam int SD = rss_pkg::DELAY_SHORT_CYC;
  localparam int MIN_D = (LONG_DELAY_CYC < SD) ? LONG_DELAY_CYC : SD;
  logic [8:0] since_reg;
  logic [12:0] oe_cnt_reg;
  // saturating, so an old watchdog event never wraps back to look fresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_reg <= 9'h1ff;
    else if (watchdog_underflow) since_reg <= 9'h000;
    else if (since_reg != 9'h1ff) since_reg <= since_reg + 9'h001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_cnt_reg <= 13'h0000;
    else if (!reset_pin_oe) oe_cnt_reg <= 13'h0000;
    else if (oe_cnt_reg != 13'h1fff) oe_cnt_reg <= oe_cnt_reg + 13'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  fetch_len_a: assert property ($rose(vector_fetch) |-> vector_fetch[*2] ##1 !vector_fetch)
    else $error("fetch phase not two cycles");
  fetch_addr_a: assert property ($rose(vector_fetch) |-> fetch_addr == 16'hfffe ##1 fetch_addr == 16'hffff)
    else $error("fetch address wrong");
  osc_kept_a: assert property (osc_run)
    else $error("oscillator stopped");
  pin_drain_a: assert property (reset_pin_oe |-> !reset_pin_out && cpu_reset)
    else $error("pin not pulled low in reset");
  delay_min_a: assert property ($fell(reset_pin_oe) |-> oe_cnt_reg >= MIN_D)
    else $error("delay phase too short");
  wdg_stretch_a: assert property ($fell(reset_pin_oe) |-> since_reg > rss_pkg::MIN_RESET_OUT_CYC)
    else $error("watchdog reset not stretched");
  wdg_react_a: assert property (watchdog_underflow |-> ##[1:2] reset_pin_oe)
    else $error("watchdog ignored");
  pin_react_a: assert property (!reset_pin_in && !reset_pin_oe |-> ##[1:5] reset_pin_oe)
    else $error("pin pulse ignored");
  cpu_release_a: assert property ($fell(cpu_reset) |-> $past(vector_fetch) || $past(vector_fetch, 2))
    else $error("cpu released without fetch");
  irq_enter_a: assert property (warning_irq_enter |-> ##2 !supply_warning_irq)
    else $error("request kept after entry");
endmodule : rss_top_chk

bind rss_top rss_top_chk #(.LONG_DELAY_CYC(LONG_DELAY_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
  .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
  .watchdog_underflow(watchdog_underflow), .cpu_reset(cpu_reset), .vector_fetch(vector_fetch),
  .fetch_addr(fetch_addr), .osc_run(osc_run), .supply_warning_irq(supply_warning_irq),
  .warning_irq_enter(warning_irq_enter));

/* testbench/rss_board.sv */
// Purpose: board side of the open-drain reset pin
// Assumes: weak pull-up on the pin
// Notes: any party pulling low wins
`timescale 1ns/1ns
module rss_board (
  // device drive
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  // external circuitry
  input wire logic ext_low,
  output logic pin_level
);
  assign pin_level = ((reset_pin_oe && !reset_pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule : rss_board

/* testbench/rss_top_tb_top.sv */
// Purpose: directed tests of rss_top
// Assumes: long delay shortened to 64 cycles
// Notes: counts taken from source event to first fetch cycle
`timescale 1ns/1ns
module rss_top_tb_top;
  localparam int LD = 64;
  localparam int W = rss_pkg::MIN_RESET_OUT_CYC;
  localparam int SD = rss_pkg::DELAY_SHORT_CYC;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_low = 1'b0;
  logic wd = 1'b0;
  logic uvb = 1'b0;
  logic wb = 1'b0;
  logic enter = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, d;
  logic pin, oe, pout, cpu_rst, vf, osc, irq;
  logic [15:0] faddr;
  logic [2:0] csel;
  int failures = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  rss_board u_board (.reset_pin_oe(oe), .reset_pin_out(pout), .ext_low(ext_low), .pin_level(pin));
  rss_top #(.LONG_DELAY_CYC(LD)) u_dut (.clk(clk), .rst_n(rst_n), .reset_pin_in(pin), .reset_pin_out(pout),
    .reset_pin_oe(oe), .watchdog_underflow(wd), .undervoltage_below(uvb), .warning_below(wb), .cpu_reset(cpu_rst),
    .vector_fetch(vf), .fetch_addr(faddr), .osc_run(osc), .clk_src_sel(csel), .supply_warning_irq(irq),
    .warning_irq_enter(enter), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %0t reset length %0d", $time, got);
    end
  endtask : chk_in
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // kind 0 watchdog, 1 short pin pulse, 2 wait only; k2 repeats the watchdog
  task automatic seq(input int kind, input int k2, input int lo, input int hi);
    int n;
    n = 0;
    if (kind == 1) begin
      @(negedge clk);
      #10 ext_low = 1'b1;
      #150 ext_low = 1'b0;
    end
    if (kind == 0) begin
      @(posedge clk);
      wd <= 1'b1;
    end
    do begin
      @(posedge clk);
      wd <= (n + 1 == k2);
      n++;
      @(negedge clk);
    end while (vf !== 1'b1 && n < 3000);
    chk_in(n, lo, hi);
    chk(17'(faddr), 17'h0fffe, "fetch lo");
    @(negedge clk);
    chk({vf, faddr}, 17'h1ffff, "fetch hi");
    repeat (2) @(negedge clk);
    chk(17'({vf, cpu_rst, oe, osc}), 17'h00001, "run state");
  endtask : seq
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    seq(2, 0, SD, SD + 8);
    rd_reg(rss_pkg::ADDR_OPTION, d);
    chk(17'(d), 17'h00000, "option");
    rd_reg(4'hf, d);
    chk(17'(d), 17'h00000, "unmapped");
    wr_reg(rss_pkg::ADDR_VECTOR_LO, 8'h5a);
    wr_reg(rss_pkg::ADDR_VECTOR_HI, 8'ha5);
    rd_reg(rss_pkg::ADDR_VECTOR_LO, d);
    chk(17'(d), 17'h0005a, "vector lo");
    rd_reg(rss_pkg::ADDR_VECTOR_HI, d);
    chk(17'(d), 17'h000a5, "vector hi");
    $display("power-up done");
    seq(0, 0, W + SD, W + SD + 12);
    rd_reg(rss_pkg::ADDR_STATUS, d);
    chk(17'(d), 17'h00001, "wdg flag");
    wr_reg(rss_pkg::ADDR_STATUS, 8'h00);
    seq(1, 0, W + SD - 2, W + SD + 12);
    rd_reg(rss_pkg::ADDR_STATUS, d);
    chk(17'(d), 17'h00000, "flags after pin");
    $display("sources done");
    for (int i = 0; i < 7; i++) begin
      wr_reg(rss_pkg::ADDR_OPTION, {1'b0, 3'(i), 2'(i % 3), 2'b11});
      rd_reg(rss_pkg::ADDR_OPTION, d);
      chk(17'({csel, d}), 17'({3'(i), 1'b0, 3'(i), 2'(i % 3), 2'b11}), "option");
    end
    seq(0, 250, 250 + W + LD, 262 + W + LD);
    @(posedge clk);
    uvb <= 1'b1;
    repeat (300) @(negedge clk);
    chk(17'({oe, cpu_rst}), 17'h00003, "uv hold");
    @(posedge clk);
    uvb <= 1'b0;
    wb <= 1'b1;
    seq(2, 0, LD, LD + 8);
    rd_reg(rss_pkg::ADDR_STATUS, d);
    chk(17'(d), 17'h00030, "uv flags");
    $display("undervoltage done");
    wr_reg(rss_pkg::ADDR_STATUS, 8'h40);
    repeat (3) @(negedge clk);
    chk(17'(irq), 17'h00001, "irq on enable");
    @(posedge clk);
    enter <= 1'b1;
    @(posedge clk);
    enter <= 1'b0;
    // request is registered, so it drops one cycle after the entry is taken
    repeat (2) @(negedge clk);
    chk(17'(irq), 17'h00000, "irq entered");
    @(posedge clk);
    wb <= 1'b0;
    repeat (4) @(negedge clk);
    chk(17'(irq), 17'h00001, "irq on toggle");
    wr_reg(rss_pkg::ADDR_ACK, 8'h00);
    repeat (2) @(negedge clk);
    chk(17'(irq), 17'h00000, "irq cleared");
    @(posedge clk);
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    wb <= 1'b1;
    seq(2, 0, W, W + LD + 12);
    repeat (4) @(negedge clk);
    chk(17'(irq), 17'h00000, "irq in reset");
    wr_reg(rss_pkg::ADDR_OPTION, 8'h01);
    rd_reg(rss_pkg::ADDR_STATUS, d);
    chk(17'(d & 8'h20), 17'h00000, "flag with uv off");
    $display("warning done");
    print_verdict();
  end
endmodule : rss_top_tb_top
